// ==== transcoder_pkg.sv ====
package transcoder_pkg;

  localparam logic [7:0] ADDR_IN_BYTE = 8'h48;
  localparam logic [7:0] ADDR_IN_WORD = 8'h49;
  localparam logic [7:0] ADDR_OUT_BYTE = 8'h4c;
  localparam logic [7:0] ADDR_OUT_WORD = 8'h4d;
  localparam logic [7:0] ADDR_FLUSH = 8'h50;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h51;
  localparam logic [7:0] ADDR_IN_FORMAT = 8'h54;
  localparam logic [7:0] ADDR_OUT_FORMAT = 8'h56;
  localparam logic [7:0] ADDR_MODE = 8'h6b;
  localparam logic [7:0] ADDR_STATUS = 8'h7e;

  // Serial frame: 8 address bits, then 8 or 16 data bits, MSB first
  localparam logic [4:0] LAST_ADDRESS_BIT = 5'h07;
  localparam logic [4:0] LAST_BYTE_BIT = 5'h0f;
  localparam logic [4:0] LAST_WORD_BIT = 5'h17;
  localparam logic [4:0] BIT_COUNT_HOLD = 5'h18;

  localparam int FLUSH_IN_BIT = 7;
  localparam int FLUSH_OUT_BIT = 15;
  localparam logic [15:0] FLUSH_BOTH = 16'h8080;

  localparam int STATUS_COUNT_OUT_BIT = 2;
  localparam int STATUS_COUNT_IN_BIT = 3;
  localparam int STATUS_IRQ_BIT = 15;

  localparam logic [1:0] RUN_IDLE = 2'h0;
  localparam logic [1:0] RUN_FULL_DUPLEX = 2'h3;
  localparam logic [3:0] PORT_HOST_FIFO = 4'h1;
  localparam logic [3:0] PORT_ANALOG = 4'h2;

  localparam logic [15:0] FORMAT_ALAW_PACKED = 16'h0011;
  localparam logic [15:0] FORMAT_LINEAR_8K = 16'h0004;

  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
  localparam logic [15:0] FORMAT_RESET = 16'h0000;

  localparam int CLOCK_HZ = 20000000;
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int SAMPLE_TICK_CYCLES = CLOCK_HZ / SAMPLE_RATE_HZ;

  typedef struct packed {
    logic [3:0] source_port;
    logic [3:0] dest_port;
    logic [15:0] input_format;
    logic [15:0] output_format;
  } channel_route_t;

endpackage : transcoder_pkg

// ==== fifo_store.sv ====
`timescale 1ns/1ns
module fifo_store #(
  parameter int WIDTH = 16,
  parameter int ADDR_WIDTH = 6
) (
  input wire logic clock,
  input wire logic write_enable,
  input wire logic [ADDR_WIDTH-1:0] write_address,
  input wire logic [WIDTH-1:0] write_data,
  input wire logic [ADDR_WIDTH-1:0] read_address,
  output logic [WIDTH-1:0] read_data
);

  logic [WIDTH-1:0] cells [0:(1<<ADDR_WIDTH)-1];

  always_ff @(posedge clock) begin
    if (write_enable) begin
      cells[write_address] <= write_data;
    end
    read_data <= cells[read_address];
  end

endmodule : fifo_store

// ==== full_duplex_transcoder_control.sv ====
// Overview of operation
// - Channel two automatically mirrors channel one reversed
// - Each channel drives exactly one output port
// - Input format also sets channel two output
// - Output format also sets channel two input
// - Mode 0120 routes FIFO-to-analog, analog-to-FIFO
// - Threshold counts raise count flags per words
// - Mode 0123 starts full-duplex transcoding
// - Starved channel stalls alone, resumes on data
// - Status bit 2 output ready, 3 consumed
// - Programming register enabled only while idle
// - Runs while low mode bits stay unchanged
// - Status read clears flags and interrupt request
`timescale 1ns/1ns
module full_duplex_transcoder_control
  import transcoder_pkg::*;
#(
  parameter int FIFO_ADDR_WIDTH = 6,
  parameter int TICK_CYCLES = SAMPLE_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serial_clock_pin,
  input wire logic serial_select_n_pin,
  input wire logic serial_data_in_pin,
  output logic serial_data_out,
  output logic serial_data_out_enable,
  input wire logic [15:0] analog_in_sample,
  input wire logic analog_in_valid,
  output logic analog_in_ready,
  output logic [15:0] analog_out_sample,
  output logic analog_out_valid,
  output logic first_channel_stalled,
  output logic second_channel_stalled,
  output logic programming_enable,
  output logic irq_request_n,
  output channel_route_t first_channel,
  output channel_route_t second_channel
);

  localparam int AW = FIFO_ADDR_WIDTH;

  function automatic logic [AW:0] next_level(input logic [AW:0] level, input logic push, input logic pop);
    next_level = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  endfunction : next_level

  function automatic logic is_readable(input logic [7:0] address);
    is_readable = (address == ADDR_OUT_BYTE) || (address == ADDR_OUT_WORD) || (address == ADDR_STATUS);
  endfunction : is_readable

  // Pin synchronisers
  logic sclk_meta, sclk_sync, sclk_last;
  logic csn_meta, csn_sync;
  logic din_meta, din_sync;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {sclk_meta, sclk_sync, sclk_last} <= 3'h0;
      {csn_meta, csn_sync} <= 2'h3;
      {din_meta, din_sync} <= 2'h0;
    end else begin
      {sclk_meta, sclk_sync, sclk_last} <= {serial_clock_pin, sclk_meta, sclk_sync};
      {csn_meta, csn_sync} <= {serial_select_n_pin, csn_meta};
      {din_meta, din_sync} <= {serial_data_in_pin, din_meta};
    end
  end

  logic [4:0] bit_count;
  logic [15:0] shift_in;
  logic [7:0] address;
  logic reading;
  logic [15:0] out_shift;

  wire sclk_rise = sclk_sync && !sclk_last && !csn_sync;
  wire [7:0] next_address = {shift_in[6:0], din_sync};
  wire [15:0] next_data = {shift_in[14:0], din_sync};
  wire address_done = sclk_rise && (bit_count == LAST_ADDRESS_BIT);
  wire read_start = address_done && is_readable(next_address);
  wire byte_written = sclk_rise && !reading && (bit_count == LAST_BYTE_BIT) && (address == ADDR_IN_BYTE);
  wire word_written = sclk_rise && !reading && (bit_count == LAST_WORD_BIT) && (address != ADDR_IN_BYTE);

  // Control registers
  logic [15:0] mode, threshold, input_format, output_format;
  logic [15:0] flags;

  wire running = (mode[1:0] == RUN_FULL_DUPLEX);
  wire mode_write = word_written && (address == ADDR_MODE);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode <= MODE_RESET;
      threshold <= THRESHOLD_RESET;
      input_format <= FORMAT_RESET;
      output_format <= FORMAT_RESET;
    end else if (word_written) begin
      if (address == ADDR_MODE) mode <= next_data;
      if (address == ADDR_THRESHOLD) threshold <= next_data;
      if (address == ADDR_IN_FORMAT) input_format <= next_data;
      if (address == ADDR_OUT_FORMAT) output_format <= next_data;
    end
  end

  // Channel two is the reverse path: same ports swapped, formats swapped
  assign first_channel = '{source_port: mode[11:8], dest_port: mode[7:4],
                           input_format: input_format, output_format: output_format};
  assign second_channel = '{source_port: mode[7:4], dest_port: mode[11:8],
                            input_format: output_format, output_format: input_format};
  assign programming_enable = (mode[1:0] == RUN_IDLE);

  // FIFO state
  logic [AW-1:0] in_wr_ptr, in_rd_ptr, out_wr_ptr, out_rd_ptr;
  logic [AW:0] in_level, out_level;
  logic [15:0] in_rd_data, out_rd_data;
  logic in_push_last;

  wire flush_write = word_written && (address == ADDR_FLUSH);
  wire flush_in = flush_write && next_data[FLUSH_IN_BIT];
  wire flush_out = flush_write && next_data[FLUSH_OUT_BIT];
  wire in_full = in_level[AW];
  wire out_full = out_level[AW];
  wire in_push = (byte_written || (word_written && address == ADDR_IN_WORD)) && !in_full;
  wire [15:0] in_push_data = byte_written ? {8'h00, next_data[7:0]} : next_data;
  wire out_pop = read_start && (next_address == ADDR_OUT_BYTE || next_address == ADDR_OUT_WORD)
                 && (out_level != '0);

  // Sample-rate enable
  logic [$clog2(TICK_CYCLES)-1:0] tick_count;
  wire sample_tick = (tick_count == '0);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) tick_count <= '0;
    else if (sample_tick) tick_count <= ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
    else tick_count <= tick_count - 1'b1;
  end

  // Channel one only feeds the analog output; channel two only the output FIFO
  wire first_routed = running && first_channel.source_port == PORT_HOST_FIFO
                      && first_channel.dest_port == PORT_ANALOG;
  wire second_routed = running && second_channel.source_port == PORT_ANALOG
                       && second_channel.dest_port == PORT_HOST_FIFO;
  wire in_has_data = (in_level != '0) && !in_push_last;
  wire in_pop = sample_tick && first_routed && in_has_data && !flush_in;
  wire out_push = sample_tick && second_routed && analog_in_valid && !out_full && !flush_out;
  assign analog_in_ready = out_push;

  fifo_store #(.WIDTH(16), .ADDR_WIDTH(AW)) in_store (
    .clock(clock),
    .write_enable(in_push),
    .write_address(in_wr_ptr),
    .write_data(in_push_data),
    .read_address(in_rd_ptr),
    .read_data(in_rd_data)
  );

  fifo_store #(.WIDTH(16), .ADDR_WIDTH(AW)) out_store (
    .clock(clock),
    .write_enable(out_push),
    .write_address(out_wr_ptr),
    .write_data(analog_in_sample),
    .read_address(out_rd_ptr),
    .read_data(out_rd_data)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_wr_ptr <= '0;
      in_rd_ptr <= '0;
      in_level <= '0;
      in_push_last <= 1'b0;
    end else begin
      in_push_last <= in_push;
      if (flush_in) begin
        in_wr_ptr <= '0;
        in_rd_ptr <= '0;
        in_level <= '0;
      end else begin
        in_wr_ptr <= in_wr_ptr + AW'(in_push);
        in_rd_ptr <= in_rd_ptr + AW'(in_pop);
        in_level <= next_level(in_level, in_push, in_pop);
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_wr_ptr <= '0;
      out_rd_ptr <= '0;
      out_level <= '0;
    end else if (flush_out) begin
      out_wr_ptr <= '0;
      out_rd_ptr <= '0;
      out_level <= '0;
    end else begin
      out_wr_ptr <= out_wr_ptr + AW'(out_push);
      out_rd_ptr <= out_rd_ptr + AW'(out_pop);
      out_level <= next_level(out_level, out_push, out_pop);
    end
  end

  // Channel outputs and stall indications
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      analog_out_sample <= 16'h0000;
      analog_out_valid <= 1'b0;
      first_channel_stalled <= 1'b0;
      second_channel_stalled <= 1'b0;
    end else begin
      analog_out_valid <= in_pop;
      if (in_pop) analog_out_sample <= in_rd_data;
      if (sample_tick) begin
        first_channel_stalled <= first_routed && !in_has_data;
        second_channel_stalled <= second_routed && !(analog_in_valid && !out_full);
      end
    end
  end

  // Frame counters against the threshold: high byte input words, low byte output words
  logic [7:0] in_frame_count, out_frame_count;
  wire [7:0] in_count_next = in_frame_count + 8'h01;
  wire [7:0] out_count_next = out_frame_count + 8'h01;
  wire count_in_event = in_pop && (in_count_next == threshold[15:8]);
  wire count_out_event = out_push && (out_count_next == threshold[7:0]);
  wire status_read = read_start && (next_address == ADDR_STATUS);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_frame_count <= 8'h00;
      out_frame_count <= 8'h00;
    end else if (mode_write) begin
      in_frame_count <= 8'h00;
      out_frame_count <= 8'h00;
    end else begin
      if (in_pop) in_frame_count <= count_in_event ? 8'h00 : in_count_next;
      if (out_push) out_frame_count <= count_out_event ? 8'h00 : out_count_next;
    end
  end

  // New events win over the clear from a status read
  wire [15:0] flag_set = (16'(count_out_event) << STATUS_COUNT_OUT_BIT)
                         | (16'(count_in_event) << STATUS_COUNT_IN_BIT);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) flags <= 16'h0000;
    else flags <= (status_read ? 16'h0000 : flags) | flag_set;
  end
  assign irq_request_n = !(|flags);
  wire [15:0] status_value = flags | (16'(!irq_request_n) << STATUS_IRQ_BIT);

  wire [15:0] read_value = (next_address == ADDR_STATUS) ? status_value :
                           (next_address == ADDR_OUT_BYTE) ? {out_rd_data[7:0], 8'h00} : out_rd_data;

  // Serial command port
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bit_count <= 5'h00;
      shift_in <= 16'h0000;
      address <= 8'h00;
      reading <= 1'b0;
      out_shift <= 16'h0000;
    end else if (csn_sync) begin
      bit_count <= 5'h00;
      reading <= 1'b0;
    end else if (sclk_rise) begin
      shift_in <= next_data;
      if (bit_count != BIT_COUNT_HOLD) bit_count <= bit_count + 5'h01;
      if (address_done) begin
        address <= next_address;
        reading <= is_readable(next_address);
        out_shift <= read_value;
      end else if (reading) begin
        out_shift <= {out_shift[14:0], 1'b0};
      end
    end
  end

  assign serial_data_out = out_shift[15];
  assign serial_data_out_enable = reading && !csn_sync;

endmodule : full_duplex_transcoder_control

// ==== transcoder_props.sv ====
`timescale 1ns/1ns
module transcoder_props
  import transcoder_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic analog_in_valid,
  input wire logic analog_in_ready,
  input wire logic analog_out_valid,
  input wire logic first_channel_stalled,
  input wire logic second_channel_stalled,
  input wire logic programming_enable,
  input wire channel_route_t first_channel,
  input wire channel_route_t second_channel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence pop_pulse;
    analog_out_valid ##1 !analog_out_valid;
  endsequence
  a_route_mirror: assert property ((second_channel.source_port == first_channel.dest_port)
    && (second_channel.dest_port == first_channel.source_port))
    else $error("second channel route not mirrored");
  a_format_mirror: assert property ((second_channel.output_format == first_channel.input_format)
    && (second_channel.input_format == first_channel.output_format))
    else $error("second channel formats not mirrored");
  a_single_dest: assert property (analog_out_valid |-> first_channel.dest_port == PORT_ANALOG)
    else $error("analog output without analog destination");
  a_out_one_pulse: assert property (analog_out_valid |-> pop_pulse)
    else $error("analog output valid longer than one cycle");
  a_out_needs_run: assert property (analog_out_valid |-> !programming_enable)
    else $error("analog output while idle");
  a_in_needs_run: assert property (analog_in_ready |-> analog_in_valid && !programming_enable)
    else $error("analog input taken while idle or not offered");
  a_in_from_analog: assert property (analog_in_ready |-> second_channel.source_port == PORT_ANALOG)
    else $error("analog input taken with other source");
  a_out_clears_stall: assert property (analog_out_valid |-> !first_channel_stalled)
    else $error("first channel stalled while producing");
  a_in_clears_stall: assert property (analog_in_ready |=> !second_channel_stalled)
    else $error("second channel stalled after taking input");
endmodule : transcoder_props
bind full_duplex_transcoder_control transcoder_props u_props (.clock(clock), .reset_n(reset_n),
  .analog_in_valid(analog_in_valid), .analog_in_ready(analog_in_ready), .analog_out_valid(analog_out_valid),
  .first_channel_stalled(first_channel_stalled), .second_channel_stalled(second_channel_stalled),
  .programming_enable(programming_enable), .first_channel(first_channel), .second_channel(second_channel));

// ==== host_port_model.sv ====
`timescale 1ns/1ns
module host_port_model (
  input wire logic clock,
  output logic serial_clock,
  output logic select_n,
  output logic data_out,
  input wire logic data_in
);
  initial begin
    serial_clock = 1'b0;
    select_n = 1'b1;
    data_out = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : pause
  // Each serial level held 5 clocks; read bits sampled just before each rise
  task automatic access(input logic [7:0] addr, input logic [15:0] wdata, input int nbits, output logic [15:0] rdata);
    logic [23:0] frame;
    frame = (nbits == 8) ? {addr, wdata[7:0], 8'h00} : {addr, wdata};
    rdata = 16'h0000;
    pause(1);
    select_n = 1'b0;
    for (int i = 0; i < 8 + nbits; i++) begin
      data_out = frame[23 - i];
      pause(5);
      if (i > 7) rdata = {rdata[14:0], data_in};
      serial_clock = 1'b1;
      pause(5);
      serial_clock = 1'b0;
    end
    select_n = 1'b1;
    data_out = ~data_out;
    pause(5);
  endtask : access
endmodule : host_port_model

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top
  import transcoder_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, sel_n, sdi, sdo, sdo_en;
  logic [15:0] ain = 16'h2000;
  int ain_left = 0;
  wire ain_valid = (ain_left != 0);
  logic ain_ready, aout_valid, stall1, stall2, prog_en, irq_n;
  logic [15:0] aout;
  channel_route_t ch1, ch2;
  logic [15:0] out_q[$];
  int n_fail = 0;
  int cmp_count = 0;
  always #25 clock = ~clock;
  host_port_model u_host (.clock(clock), .serial_clock(sclk), .select_n(sel_n), .data_out(sdi), .data_in(sdo));
  full_duplex_transcoder_control #(.TICK_CYCLES(8)) u_dut (.clock(clock), .reset_n(reset_n),
    .serial_clock_pin(sclk), .serial_select_n_pin(sel_n), .serial_data_in_pin(sdi), .serial_data_out(sdo),
    .serial_data_out_enable(sdo_en), .analog_in_sample(ain_valid ? ain : ~ain), .analog_in_valid(ain_valid),
    .analog_in_ready(ain_ready), .analog_out_sample(aout), .analog_out_valid(aout_valid),
    .first_channel_stalled(stall1), .second_channel_stalled(stall2), .programming_enable(prog_en),
    .irq_request_n(irq_n), .first_channel(ch1), .second_channel(ch2));
  always @(posedge clock) begin
    if (ain_ready) begin
      ain <= ain + 16'h0101;
      ain_left <= ain_left - 1;
    end
    if (aout_valid) out_q.push_back(aout);
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int nb = 16);
    logic [15:0] r;
    u_host.access(a, d, nb, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input int nb, input logic [15:0] exp, input string what);
    logic [15:0] r;
    u_host.access(a, 16'h0000, nb, r);
    chk(what, exp, r);
  endtask : rd
  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    #(50 * 30000);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clock);
    #2 reset_n = 1'b1;
    repeat (3) @(posedge clock);
    chk("idle prog", 16'h0001, {15'h0, prog_en});
    chk("idle irq", 16'h0001, {15'h0, irq_n});
    wr(ADDR_IN_WORD, 16'hdead);
    wr(ADDR_FLUSH, FLUSH_BOTH);
    wr(ADDR_IN_FORMAT, FORMAT_ALAW_PACKED);
    chk("ch1 in fmt", 16'h0011, ch1.input_format);
    chk("ch2 out fmt", 16'h0011, ch2.output_format);
    wr(ADDR_OUT_FORMAT, FORMAT_LINEAR_8K);
    chk("ch1 out fmt", 16'h0004, ch1.output_format);
    chk("ch2 in fmt", 16'h0004, ch2.input_format);
    wr(ADDR_MODE, 16'h0120);
    chk("ch1 ports", 16'h0012, {8'h00, ch1.source_port, ch1.dest_port});
    chk("ch2 ports", 16'h0021, {8'h00, ch2.source_port, ch2.dest_port});
    wr(8'h60, 16'h0003);
    chk("unmapped write", 16'h0001, {15'h0, prog_en});
    for (int i = 0; i < 4; i++) wr(ADDR_IN_WORD, 16'h1000 + 16'(i));
    wr(ADDR_IN_BYTE, 16'h00a5, 8);
    wr(ADDR_THRESHOLD, 16'h0505);
    wr(ADDR_MODE, 16'h0123);
    chk("run prog", 16'h0000, {15'h0, prog_en});
    repeat (100) @(posedge clock);
    chk("pops", 16'h0005, 16'(out_q.size()));
    for (int i = 0; i < 5; i++) chk("ch1 data", (i < 4) ? 16'h1000 + 16'(i) : 16'h00a5, out_q[i]);
    #2 chk("stall both", 16'h0011, {11'h0, stall1, 3'h0, stall2});
    ain_left = 5;
    repeat (20) @(posedge clock);
    #2 chk("stalls", 16'h0010, {11'h0, stall1, 3'h0, stall2});
    repeat (60) @(posedge clock);
    chk("irq set", 16'h0000, {15'h0, irq_n});
    rd(ADDR_STATUS, 16, 16'h800c, "status");
    chk("irq cleared", 16'h0001, {15'h0, irq_n});
    chk("out enable", 16'h0000, {15'h0, sdo_en});
    rd(ADDR_STATUS, 16, 16'h0000, "status again");
    for (int i = 0; i < 4; i++) rd(ADDR_OUT_WORD, 16, 16'h2000 + 16'h0101 * 16'(i), "ch2 data");
    rd(ADDR_OUT_BYTE, 8, 16'h0004, "ch2 byte");
    wr(ADDR_IN_WORD, 16'h3c3c);
    repeat (40) @(posedge clock);
    chk("resume", 16'h3c3c, out_q[out_q.size() - 1]);
    wr(ADDR_MODE, 16'h0120);
    wr(ADDR_IN_WORD, 16'h4444);
    repeat (40) @(posedge clock);
    chk("stopped", 16'h0006, 16'(out_q.size()));
    chk("stop prog", 16'h0001, {15'h0, prog_en});
    end_of_test();
  end
endmodule : tb_top
